// ==== hdl/sfdr_host.v ====
// Host controller issuing double-rate reads to a serial flash.
// Assumes the flash is on the far side of O_SCK/O_CS_N and the data lines;
// software talks over a plain strobe port with read data one cycle later.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "sfdr_map.vh"

module sfdr_host #(
    parameter HALF = `SFDR_HALF_CYC               // System clocks per half serial clock, >=4
) (
    input  wire        I_CLK,                     // System clock
    input  wire        I_ARST_N,                  // Async reset, active low
    input  wire [4:0]  I_ADDR,                    // Register byte address
    input  wire [31:0] I_WDATA,                   // Write data
    input  wire        I_WR,                      // Write strobe
    input  wire        I_RD,                      // Read strobe
    output reg  [31:0] O_RDATA,                   // Read data, cycle after I_RD
    output reg         O_CS_N,                    // Flash chip select, active low
    output reg         O_SCK,                     // Flash serial clock
    input  wire [3:0]  I_DQ,                      // Data lines in
    output reg  [3:0]  O_DQ,                      // Data lines out
    output reg  [3:0]  O_DQ_OE_N                  // Data line enables, low drives
);

    // -------------------------------------------------------------------------
    // States
    // -------------------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h0;             // Select high, waiting
    localparam [2:0] ST_SETUP = 3'h1;             // Select low, first edge pending
    localparam [2:0] ST_OPC   = 3'h2;             // Opcode phase
    localparam [2:0] ST_ADR   = 3'h3;             // Address phase
    localparam [2:0] ST_DUM   = 3'h4;             // Dummy and mode bits
    localparam [2:0] ST_DAT   = 3'h5;             // Data output from flash
    localparam [2:0] ST_DONE  = 3'h6;             // Select high guard beat

    localparam integer MID_I = HALF / 2 - 1;    // Output update point in half period
    localparam integer TOG_I = HALF - 1;        // Sample and edge point
    // Cut to the divider width on purpose
    localparam [7:0] MID_AT = MID_I[7:0];
    localparam [7:0] TOG_AT = TOG_I[7:0];

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Top bits of a shift word onto the lines for a lane width of 1, 2 or 4
    function [3:0] chunk;
        input [31:0] v;
        input [1:0]  lw;
        begin
            case (lw)
                2'h0:    chunk = {3'h0, v[31]};
                2'h1:    chunk = {2'h0, v[31:30]};
                default: chunk = v[31:28];
            endcase
        end
    endfunction

    // Enables for the lanes in use
    function [3:0] lanes_n;
        input [1:0] lw;
        begin
            case (lw)
                2'h0:    lanes_n = 4'he;
                2'h1:    lanes_n = 4'hc;
                default: lanes_n = 4'h0;
            endcase
        end
    endfunction

    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    reg  [3:0]  dq_s1;                            // Synchroniser stage one
    reg  [3:0]  dq_s2;                            // Synchroniser stage two
    reg  [7:0]  div;                              // Half period divider
    reg  [2:0]  state;                            // Sequencer state
    reg  [8:0]  beat;                             // Beats left in phase
    reg  [31:0] sh;                               // Outgoing shift word
    reg  [1:0]  mb_left;                          // Mode beats still driven
    reg         skip;                             // Opcode skip active
    reg         got;                              // A data edge has passed
    reg  [7:0]  rxsh;                             // Incoming shift byte
    reg  [3:0]  rxcnt;                            // Bits in rxsh
    reg  [7:0]  rx_byte;                          // Last whole byte
    reg         rx_valid;                         // Byte waiting for software
    reg  [15:0] bytes_left;                       // Bytes still to read
    reg  [31:0] cur_addr;                         // Address of next byte
    reg  [1:0]  cfg_mode;                         // Line mode
    reg         cfg_wide;                         // Wide-address opcode
    reg         cfg_ext;                          // Extended address flag copy
    reg  [7:0]  cfg_dummy;                        // Dummy clocks
    reg  [7:0]  cfg_mbyte;                        // Mode byte for dual reads
    reg  [31:0] cfg_addr;                         // Start address
    reg  [15:0] cfg_count;                        // Byte count

    wire        busy   = (state != ST_IDLE);
    wire        mid    = (div == MID_AT);
    wire        tog    = (div == TOG_AT);
    wire        is_q   = (cfg_mode == `SFDR_MODE_QUAD);
    wire        is_d   = (cfg_mode == `SFDR_MODE_DUAL);
    wire [1:0]  lw     = is_q ? 2'h2 : (is_d ? 2'h1 : 2'h0);
    wire [2:0]  wbits  = 3'h1 << lw;
    wire [1:0]  opc_lw = is_q ? 2'h2 : 2'h0;
    wire [8:0]  opc_bt = is_q ? 9'h004 : 9'h010;
    wire        a32    = cfg_wide | cfg_ext;
    wire [8:0]  adr_bt = a32 ? (9'h020 >> lw) : (9'h018 >> lw);
    wire [31:0] adr_al = a32 ? cfg_addr : {cfg_addr[23:0], 8'h00};
    wire [7:0]  opcode = is_d ? (cfg_wide ? `SFDR_OPC_DUAL4 : `SFDR_OPC_DUAL)
                              : (cfg_wide ? `SFDR_OPC_SINGLE4 : `SFDR_OPC_SINGLE);
    wire [31:0] opc_w  = {opcode, 24'h000000};
    wire [31:0] mb_w   = {cfg_mbyte, 24'h000000};
    wire [3:0]  samp   = (lw == 2'h0) ? {3'h0, dq_s2[1]} :
                         ((lw == 2'h1) ? {2'h0, dq_s2[1:0]} : dq_s2);
    wire [7:0]  rx_nxt = (rxsh << wbits) | {4'h0, samp};
    wire [3:0]  rx_sum = rxcnt + {1'b0, wbits};
    wire        go     = I_WR && (I_ADDR == `SFDR_REG_CTRL) && I_WDATA[`SFDR_CTRL_GO] && !busy;
    wire        abort  = I_WR && (I_ADDR == `SFDR_REG_CTRL) && I_WDATA[`SFDR_CTRL_ABORT]
                         && (state == ST_DAT);
    wire        pop    = I_RD && (I_ADDR == `SFDR_REG_RXDATA);
    wire        run_ok = (state == ST_OPC) || (state == ST_ADR) || (state == ST_DUM) ||
                         ((state == ST_DAT) && !rx_valid);

    // -------------------------------------------------------------------------
    // Input synchroniser
    // -------------------------------------------------------------------------
    // Two flops; only the second is read by the data path
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            dq_s1 <= 4'h0;
            dq_s2 <= 4'h0;
        end else begin
            dq_s1 <= I_DQ;
            dq_s2 <= dq_s1;
        end
    end

    // -------------------------------------------------------------------------
    // Serial clock divider
    // -------------------------------------------------------------------------
    // Free running; events simply fall where the sequencer needs them
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            div <= 8'h00;
        end else begin
            div <= tog ? 8'h00 : div + 8'h01;
        end
    end

    // -------------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------------
    // Frozen while a read runs so the sequence cannot change mid-flight
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cfg_mode  <= `SFDR_MODE_SINGLE;
            cfg_wide  <= 1'b0;
            cfg_ext   <= 1'b0;
            cfg_dummy <= `SFDR_DUMMY_RST;
            cfg_mbyte <= `SFDR_MBYTE_RST;
            cfg_addr  <= 32'h00000000;
            cfg_count <= 16'h0001;
        end else if (I_WR && !busy) begin
            case (I_ADDR)
                `SFDR_REG_CFG: begin
                    cfg_mode  <= I_WDATA[1:0];
                    cfg_wide  <= I_WDATA[`SFDR_CFG_WIDE];
                    cfg_ext   <= I_WDATA[`SFDR_CFG_EXT];
                    cfg_dummy <= I_WDATA[`SFDR_CFG_DUM_LSB +: 8];
                    cfg_mbyte <= I_WDATA[`SFDR_CFG_MB_LSB +: 8];
                end
                `SFDR_REG_ADDR:  cfg_addr  <= I_WDATA;
                `SFDR_REG_COUNT: cfg_count <= I_WDATA[15:0];
                default: ;                        // Other offsets hold nothing here
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Read sequencer
    // -------------------------------------------------------------------------
    // Mid points update the lines, toggle points sample and make the edge
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state      <= ST_IDLE;
            beat       <= 9'h000;
            sh         <= 32'h00000000;
            mb_left    <= 2'h0;
            skip       <= 1'b0;
            got        <= 1'b0;
            rxsh       <= 8'h00;
            rxcnt      <= 4'h0;
            rx_byte    <= 8'h00;
            rx_valid   <= 1'b0;
            bytes_left <= 16'h0000;
            cur_addr   <= 32'h00000000;
            O_CS_N     <= 1'b1;
            O_SCK      <= 1'b0;
            O_DQ       <= 4'h0;
            O_DQ_OE_N  <= 4'hf;
        end else begin
            if (pop) begin
                rx_valid <= 1'b0;
            end
            if (go) begin
                state      <= ST_SETUP;
                O_CS_N     <= 1'b0;
                bytes_left <= cfg_count;
                cur_addr   <= cfg_addr;
            end else if (abort) begin
                state     <= ST_DONE;             // Select rises mid data
                O_CS_N    <= 1'b1;
                O_SCK     <= 1'b0;
                O_DQ_OE_N <= 4'hf;
            end else if (mid) begin
                case (state)
                    ST_SETUP: begin
                        if (skip && is_d) begin   // Address first
                            O_DQ      <= chunk(adr_al, lw);
                            O_DQ_OE_N <= lanes_n(lw);
                            sh        <= adr_al << wbits;
                            beat      <= adr_bt - 9'h001;
                            state     <= ST_ADR;
                        end else begin            // Full opcode
                            O_DQ      <= chunk(opc_w, opc_lw);
                            O_DQ_OE_N <= lanes_n(opc_lw);
                            sh        <= opc_w << (3'h1 << opc_lw);
                            beat      <= opc_bt - 9'h001;
                            state     <= ST_OPC;
                        end
                    end
                    ST_OPC: begin
                        if (beat == 9'h000) begin // Address on both edges
                            O_DQ      <= chunk(adr_al, lw);
                            O_DQ_OE_N <= lanes_n(lw);
                            sh        <= adr_al << wbits;
                            beat      <= adr_bt - 9'h001;
                            state     <= ST_ADR;
                        end else begin
                            beat <= beat - 9'h001;
                            if (!O_SCK) begin     // Opcode changes only before a rise
                                O_DQ <= chunk(sh, opc_lw);
                                sh   <= sh << (3'h1 << opc_lw);
                            end
                        end
                    end
                    ST_ADR: begin
                        if (beat == 9'h000) begin
                            beat  <= {cfg_dummy, 1'b0} - 9'h001;
                            state <= ST_DUM;
                            if (is_d) begin       // Mode byte, upper nibble first
                                O_DQ      <= chunk(mb_w, 2'h1);
                                O_DQ_OE_N <= 4'hc;
                                sh        <= mb_w << 2;
                                mb_left   <= (cfg_dummy > 8'h02) ? 2'h3 : 2'h1;
                                skip      <= (cfg_mbyte[7:4] == `SFDR_SKIP_NIB);
                            end else if (is_q) begin
                                O_DQ_OE_N <= 4'hf; // No mode bits here
                            end else begin
                                O_DQ      <= 4'h0; // Line 0 held low in dummy
                                O_DQ_OE_N <= 4'he;
                            end
                        end else begin
                            beat <= beat - 9'h001;
                            O_DQ <= chunk(sh, lw);
                            sh   <= sh << wbits;
                        end
                    end
                    ST_DUM: begin
                        if (beat == 9'h000) begin // Flash takes the lines
                            O_DQ_OE_N <= 4'hf;
                            got       <= 1'b0;
                            rxcnt     <= 4'h0;
                            state     <= ST_DAT;
                        end else begin
                            beat <= beat - 9'h001;
                            if (is_d && (mb_left != 2'h0)) begin
                                O_DQ    <= chunk(sh, 2'h1);
                                sh      <= sh << 2;
                                mb_left <= mb_left - 2'h1;
                            end else if (is_d) begin
                                O_DQ_OE_N <= 4'hf; // Released before turnaround
                            end
                        end
                    end
                    ST_DONE: begin
                        state <= ST_IDLE;         // Ready for next command
                    end
                    default: ;                    // Idle and data wait for toggles
                endcase
            end else if (tog && run_ok) begin
                // Stalls while a byte is unread; no edge means the flash holds
                if ((state == ST_DAT) && got) begin
                    if (rx_sum == 4'h8) begin
                        rx_byte    <= rx_nxt;
                        rx_valid   <= 1'b1;       // Set wins over a pop
                        rxcnt      <= 4'h0;
                        cur_addr   <= cur_addr + 32'h00000001;
                        bytes_left <= bytes_left - 16'h0001;
                        if (bytes_left == 16'h0001) begin
                            O_CS_N <= 1'b1;       // Last byte, end the read
                            state  <= ST_DONE;
                        end else begin
                            O_SCK <= ~O_SCK;
                        end
                    end else begin
                        rxsh  <= rx_nxt;
                        rxcnt <= rx_sum;
                        O_SCK <= ~O_SCK;
                    end
                end else begin
                    got   <= (state == ST_DAT);
                    O_SCK <= ~O_SCK;
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Register read port
    // -------------------------------------------------------------------------
    // Registered, one cycle after the strobe; unmapped reads give zero
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RDATA <= 32'h00000000;
        end else if (I_RD) begin
            case (I_ADDR)
                `SFDR_REG_CFG:     O_RDATA <= {8'h00, cfg_mbyte, cfg_dummy, 4'h0,
                                               cfg_ext, cfg_wide, cfg_mode};
                `SFDR_REG_ADDR:    O_RDATA <= cfg_addr;
                `SFDR_REG_COUNT:   O_RDATA <= {16'h0000, cfg_count};
                `SFDR_REG_STATUS:  O_RDATA <= {29'h00000000, skip, rx_valid, busy};
                `SFDR_REG_RXDATA:  O_RDATA <= {24'h000000, rx_byte};
                `SFDR_REG_CURADDR: O_RDATA <= cur_addr;
                default:           O_RDATA <= 32'h00000000;
            endcase
        end else begin
            O_RDATA <= 32'h00000000;
        end
    end

endmodule // sfdr_host

// ==== hdl/sfdr_map.vh ====
// Constants for the host-side controller of a serial flash double-rate read.
// Assumes a 200 MHz system clock and a flash whose lines are resolved by the bench.
`ifndef SFDR_MAP_VH
`define SFDR_MAP_VH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define SFDR_REG_CTRL    5'h00
`define SFDR_REG_CFG     5'h04
`define SFDR_REG_ADDR    5'h08
`define SFDR_REG_COUNT   5'h0c
`define SFDR_REG_STATUS  5'h10
`define SFDR_REG_RXDATA  5'h14
`define SFDR_REG_CURADDR 5'h18

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define SFDR_CTRL_GO     0
`define SFDR_CTRL_ABORT  1
`define SFDR_CFG_WIDE    2
`define SFDR_CFG_EXT     3
`define SFDR_CFG_DUM_LSB 8
`define SFDR_CFG_MB_LSB  16

// -----------------------------------------------------------------------------
// Modes, opcodes, reset values, timing
// -----------------------------------------------------------------------------
`define SFDR_MODE_SINGLE 2'h0
`define SFDR_MODE_QUAD   2'h1
`define SFDR_MODE_DUAL   2'h2
`define SFDR_OPC_SINGLE  8'h0d
`define SFDR_OPC_SINGLE4 8'h0e
`define SFDR_OPC_DUAL    8'hbd
`define SFDR_OPC_DUAL4   8'hbe
`define SFDR_SKIP_NIB    4'ha
`define SFDR_DUMMY_RST   8'h08
`define SFDR_MBYTE_RST   8'hff
`define SFDR_HALF_CYC    4

`endif

// ==== sim/sfdr_host_sva.sv ====
// Checker for the flash pins of the double-rate read host.
// Assumes the half serial period is four system clocks.
`timescale 1ns/10ps
module sfdr_host_sva #(
    parameter HALF = 4                    // Half serial period in system clocks
) (
    input wire       I_CLK,               // System clock
    input wire       I_ARST_N,            // Async reset, active low
    input wire       O_CS_N,              // Flash select, active low
    input wire       O_SCK,               // Serial clock
    input wire [3:0] O_DQ,                // Data lines out
    input wire [3:0] O_DQ_OE_N            // Line enables, low drives
);
    // ----------------------------------------------------------------
    // Pin rules; counts assume HALF of four
    // ----------------------------------------------------------------
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    AST_SCK_IDLE: assert property (O_CS_N && $past(O_CS_N) |-> !O_SCK)
        else $error("serial clock high while deselected");
    AST_OE_IDLE: assert property (O_CS_N && $past(O_CS_N) |-> O_DQ_OE_N == 4'hf)
        else $error("lines driven while deselected");
    AST_SCK_HIGH: assert property ($rose(O_SCK) |-> (O_SCK || O_CS_N)[*4])
        else $error("serial clock high phase too short");
    AST_SCK_LOW: assert property ($fell(O_SCK) && !O_CS_N |-> (!O_SCK)[*4])
        else $error("serial clock low phase too short");
    AST_DQ_MID: assert property (!O_CS_N && $changed(O_SCK)
        |-> $stable(O_DQ) && $stable(O_DQ_OE_N))
        else $error("lines change on a clock edge");
    AST_SEL_LOW: assert property ($fell(O_CS_N) |-> !O_SCK)
        else $error("select falls with clock high");
    AST_START: assert property ($fell(O_CS_N) |-> ##[1:8] !O_DQ_OE_N[0])
        else $error("no command after select");
    AST_OE_SET: assert property (!O_CS_N |-> O_DQ_OE_N inside {4'hf, 4'he, 4'hc, 4'h0})
        else $error("illegal line enable set");
    AST_DESEL_HOLD: assert property ($rose(O_CS_N) |-> O_CS_N[*4])
        else $error("select high too briefly");
    // Covers: read end, four-line, dual
    cover property ($rose(O_CS_N));
    cover property (!O_CS_N && O_DQ_OE_N == 4'h0);
    cover property (!O_CS_N && O_DQ_OE_N == 4'hc);
endmodule // sfdr_host_sva
bind sfdr_host sfdr_host_sva #(.HALF(HALF)) u_sva (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .O_CS_N(O_CS_N), .O_SCK(O_SCK), .O_DQ(O_DQ), .O_DQ_OE_N(O_DQ_OE_N));

// ==== sim/sfdr_flash_mdl.sv ====
// Behavioural flash answering double-rate reads on both clock edges.
// Assumes the bench resolves the lines and sets mode, flag and dummy count.
`timescale 1ns/10ps
module sfdr_flash_mdl (
    input  wire       cs_n,   // Select from host
    input  wire       sck,    // Serial clock from host
    input  wire [3:0] dq,     // Resolved data lines
    input  wire       busy,   // Program or erase cycle running
    input  wire       quad,   // Four-line command mode
    input  wire       ext,    // Extended address flag
    input  wire [7:0] dum,    // Dummy clocks from read parameter
    output reg  [3:0] q       // Lines as the flash drives them
);
    reg [7:0]  op, sop;       // Opcode, and the dual one kept for skips
    reg [31:0] a, b;          // Start and current byte address
    reg [1:0]  mb;            // First half of mode nibble
    reg        pc = 1'b1;     // Select was high
    reg        go, skip = 1'b0;
    integer    oc, e, w, na, j;
    function [7:0] mem(input [31:0] x);  // Array content
        mem = x[7:0] + x[15:8] + x[23:16] + x[31:24] + 8'h11;
    endfunction
    initial q = 4'h5;
    // ----------------------------------------------------------------
    // Edge engine; released lines show the inverse
    // ----------------------------------------------------------------
    always @(posedge sck or negedge sck or posedge cs_n or negedge cs_n) begin
        if (cs_n) begin                  // Released: inverted level
            q = ~q;
            pc = 1'b1;
        end else if (pc) begin           // Select just fell
            pc = 1'b0;
            go = !busy;
            e = 0;
            oc = (skip && !quad) ? 8 : 0;
            if (skip && !quad) op = sop;
            a = 0;
        end else if (!go) begin          // Rejected, cycle untouched
            q = ~q;
        end else if (oc < (quad ? 2 : 8)) begin
            if (sck) begin
                op = quad ? {op[3:0], dq} : {op[6:0], dq[0]};
                oc = oc + 1;
            end
            e = -1;
        end else begin
            w = quad ? 4 : (op[7] ? 2 : 1);
            na = ((op[1] | ext) ? 32 : 24) / w;
            if (e >= 0 && e < na) a = (a << w) | (dq & ((1 << w) - 1));
            if (e == na) mb = dq[1:0];
            if (e == na && w == 2) sop = op;
            if (e == na + 1 && w == 2) skip = ({mb, dq[1:0]} == 4'ha);
            j = e - na - 2 * dum;
            if (j >= 0) begin
                b = a + j * w / 8;
                if (na * w == 24) b[31:24] = 8'h00;
                q = ((mem(b) >> (8 - w - j * w % 8)) & ((1 << w) - 1)) << (w == 1);
            end else begin
                q = ~q;
            end
            e = e + 1;
        end
    end
endmodule // sfdr_flash_mdl

// ==== sim/test_sfdr_host.sv ====
// Self-checking bench: host reads a behavioural flash over every mode.
// Assumes the map header on the include path and the bound checker.
`timescale 1ns/10ps
`include "sfdr_map.vh"
module test_sfdr_host;
    reg          I_CLK, I_ARST_N, I_WR, I_RD;  // Clock, reset, strobes
    reg  [4:0]   I_ADDR;                       // Register address
    reg  [31:0]  I_WDATA;                      // Write data
    wire [31:0]  O_RDATA;                      // Read data
    wire         O_CS_N, O_SCK;                // Select and serial clock
    wire [3:0]   O_DQ, O_DQ_OE_N, mdl_q, dq_w; // Line signals
    reg          m_quad, m_ext, chk, sk;       // Model setup, marks
    reg          chk_d = 1'b0;                 // Read data due now
    reg  [7:0]   m_dum;                        // Model dummy clocks
    logic [63:0] eq[$];                        // Notes {expected, mask}
    logic [63:0] ex;                           // Note under test
    reg  [31:0]  s;                            // Scratch read data
    integer      mismatches = 0, n_tests = 0;
    // Wire level: host where enabled, flash elsewhere
    assign dq_w = (O_DQ & ~O_DQ_OE_N) | (mdl_q & O_DQ_OE_N);
    sfdr_host DUT (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
        .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_CS_N(O_CS_N), .O_SCK(O_SCK),
        .I_DQ(dq_w), .O_DQ(O_DQ), .O_DQ_OE_N(O_DQ_OE_N));
    sfdr_flash_mdl FLASH (.cs_n(O_CS_N), .sck(O_SCK), .dq(dq_w), .busy(1'b0),
        .quad(m_quad), .ext(m_ext), .dum(m_dum), .q(mdl_q));
    initial begin
        I_CLK = 1'b0;
        forever #2.5 I_CLK = ~I_CLK;
    end
    // ----------------------------------------------------------------
    // Bus tasks; a zero mask reads without a note
    // ----------------------------------------------------------------
    task wr(input [4:0] ad, input [31:0] d);
        @(posedge I_CLK);
        I_ADDR <= ad;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    task rd(input [4:0] ad, input [31:0] x, input [31:0] m, output [31:0] d);
        @(posedge I_CLK);
        I_ADDR <= ad;
        I_RD <= 1'b1;
        chk <= (m != 0);
        if (m != 0) eq.push_back({x, m});
        @(posedge I_CLK);
        I_RD <= 1'b0;
        chk <= 1'b0;
        #1 d = O_RDATA;
    endtask
    task wt(input integer bt, input v);  // Bounded status poll
        integer k;
        s[bt] = ~v;
        for (k = 0; k < 3000 && s[bt] !== v; k++) rd(`SFDR_REG_STATUS, 0, 0, s);
        if (s[bt] !== v) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: status bit %0d stuck", $time, bt);
        end
    endtask
    task run(input [1:0] md, input w, x, input [7:0] dm, mb, input [31:0] ad,
             input [3:0] n, input ab);
        integer i;
        reg [31:0] a;
        m_quad = (md == `SFDR_MODE_QUAD);
        m_ext = x;
        m_dum = dm;
        wr(`SFDR_REG_CFG, {8'h00, mb, dm, 4'h0, x, w, md});
        wr(`SFDR_REG_ADDR, ad);
        wr(`SFDR_REG_COUNT, {28'h0, n});
        wr(`SFDR_REG_CTRL, 32'h1);
        a = ad;
        s = 0;
        for (i = 0; i < n; i++) begin
            if (!(w | x)) a[31:24] = 8'h00;
            if (ab && i == 1) begin      // Stop mid data
                wr(`SFDR_REG_CTRL, 32'h2);
                break;
            end
            wt(1, 1'b1);
            rd(`SFDR_REG_RXDATA, {24'h0, FLASH.mem(a)}, 32'hff, s);
            a = a + 1;
            s = 0;
        end
        wt(0, 1'b0);
        rd(`SFDR_REG_RXDATA, 0, 0, s);
        if (md == `SFDR_MODE_DUAL) sk = (mb[7:4] == `SFDR_SKIP_NIB);
        rd(`SFDR_REG_STATUS, {29'h0, sk, 2'b00}, 32'h7, s);
    endtask
    // Compare each note with its read data
    always @(posedge I_CLK) begin
        chk_d <= chk;
        if (chk_d) begin
            ex = eq.pop_front();
            n_tests = n_tests + 1;
            if ((O_RDATA & ex[31:0]) !== (ex[63:32] & ex[31:0])) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: read %h want %h", $time, O_RDATA, ex[63:32]);
            end
        end
    end
    task summarize;
        $display("mismatches %0d, checks %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin  // Watchdog
        #400000;
        mismatches = mismatches + 1;
        summarize;
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {I_ARST_N, I_WR, I_RD, chk, sk, m_quad, m_ext} = 0;
        I_ADDR = 0;
        I_WDATA = 0;
        m_dum = 8;
        void'($urandom(39248));
        repeat (3) @(posedge I_CLK);
        I_ARST_N <= 1'b1;
        rd(`SFDR_REG_CFG, 32'h00ff0800, ~0, s);
        rd(5'h1c, 0, ~0, s);
        run(0, 0, 0, 8, 8'hff, $urandom, 3, 0);
        run(0, 1, 0, 8, 8'hff, $urandom, 2, 0);
        run(0, 0, 1, 2, 8'hff, $urandom, 2, 0);
        run(1, 0, 0, 6, 8'hff, $urandom, 2, 0);
        run(1, 1, 0, 6, 8'hff, $urandom, 1, 0);
        run(2, 0, 0, 4, 8'ha5, 32'h00fffffe, 3, 0);
        run(1, 0, 1, 6, 8'hff, $urandom, 1, 0);
        run(2, 0, 0, 2, 8'h35, $urandom, 2, 0);
        run(2, 1, 0, 4, 8'hff, $urandom, 2, 0);
        run(0, 0, 0, 8, 8'hff, $urandom, 4, 1);
        repeat (4) @(posedge I_CLK);
        summarize;
    end
endmodule // test_sfdr_host
